//--- sif_defines.svh
// Constants for the link-side request and control interface of the serial bus port.
`ifndef SIF_DEFINES_SVH
`define SIF_DEFINES_SVH
// Control pair codes as vector values: index 0 is control bit 0, index 1 is control bit 1.
`define SIF_CTL_IDLE 2'h0
`define SIF_CTL_STATUS 2'h2
`define SIF_CTL_RECV 2'h1
`define SIF_CTL_GRANT 2'h3
`define SIF_LCTL_RELEASE 2'h0
`define SIF_LCTL_HOLD 2'h2
`define SIF_LCTL_XMIT 2'h1
`define SIF_LCTL_RSVD 2'h3
// Request type codes.
`define SIF_RT_IMM 3'h0
`define SIF_RT_ISO 3'h1
`define SIF_RT_PRI 3'h2
`define SIF_RT_FAIR 3'h3
`define SIF_RT_REG_RD 3'h4
`define SIF_RT_REG_WR 3'h5
`define SIF_RT_ACCEL 3'h6
`define SIF_RT_RSVD 3'h7
// Speed codes.
`define SIF_SPD_S100 3'h0
`define SIF_SPD_S200 3'h2
`define SIF_SPD_S400 3'h4
// Stream lengths in bits, start and stop bits included.
`define SIF_LEN_TYPE 5'h04
`define SIF_LEN_ACCEL 5'h06
`define SIF_LEN_BUS_SHORT 5'h07
`define SIF_LEN_BUS_LONG 5'h08
`define SIF_LEN_REG_RD 5'h09
`define SIF_LEN_REG_WR 5'h11
// Status transfer: sixteen bits, two bits per cycle.
`define SIF_STAT_CYC 4'h8
`define SIF_STAT_PAD 4'h0
`endif

//--- sif_pkg.sv
// Types shared by the link-side interface modules.
package sif_pkg;
  typedef enum logic [2:0] {SIF_BS_IDLE, SIF_BS_STATUS, SIF_BS_RECV, SIF_BS_GRANT,
                            SIF_BS_LLC} sif_bus_st_t;
  typedef enum logic [1:0] {SIF_RQ_IDLE, SIF_RQ_BITS, SIF_RQ_FLUSH} sif_rq_st_t;
  typedef struct packed {
    sif_bus_st_t bus;
    sif_rq_st_t rq;
    logic [4:0] cnt;
    logic [15:0] sr;
    logic [2:0] rtype;
    logic bus_pend;
    logic won;
    logic [2:0] bus_type;
    logic [2:0] bus_spd;
    logic rd_pend;
    logic [3:0] rd_addr;
    logic [15:0] stat_sr;
    logic [3:0] stat_cnt;
    logic stat_auto;
    logic [1:0] ctl;
    logic [7:0] d;
    logic own;
    logic [1:0] ctl_oe;
    logic [7:0] d_oe;
    logic wr_v;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic acc_v;
    logic acc_en;
    logic tx_v;
    logic [7:0] tx_d;
    logic null_tx;
    logic stat_ack;
    logic iso_m;
    logic iso_s;
  } sif_state_t;
  typedef struct packed {
    logic [8:0] e0;
    logic [8:0] e1;
    logic [1:0] cnt;
  } sif_buf_state_t;
endpackage

//--- sif_buf.sv
// Two-entry buffer in the receive data path.
`timescale 1ns/1ps
module sif_buf import sif_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [8:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [8:0] out_data
);
  sif_buf_state_t s_ff;
  sif_buf_state_t nxt_s;
  logic push;
  logic pop;

  // Handshakes come straight from the fill level; data leaves from the head flop.
  assign in_ready = (s_ff.cnt != 2'h2);
  assign out_valid = (s_ff.cnt != 2'h0);
  assign out_data = s_ff.e0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: the head shifts forward on a pop, new words land behind it.
  always_comb begin
    nxt_s = s_ff;
    if (pop) begin
      nxt_s.e0 = s_ff.e1;
    end
    if (push) begin
      if ((s_ff.cnt == 2'h0) || (pop && (s_ff.cnt == 2'h1))) begin
        nxt_s.e0 = in_data;
      end else if (pop) begin
        nxt_s.e1 = in_data;
      end else begin
        nxt_s.e1 = in_data;
      end
    end
    nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // sif_buf

//--- sif_link_port.sv
// Device-side control, data and request logic of the link-layer interface.
`timescale 1ns/1ps
`include "sif_defines.svh"
// Functional notes
// - Status transfers start autonomously or answer a pending register read.
// - Every packet arriving from the serial bus starts a receive operation.
// - After winning arbitration, grant code hands the interface to the link.
// - Device drives idle, status, receive and grant codes while owning control.
// - Differentiation is enabled while the isolation select input is low.
// - Differentiated outputs drive one cycle per change, else float.
// - Inputs keep their previous state while the line floats.
// - Lengths: bus 7 or 8, read 9, write 17, acceleration 6 bits.
// - Stream starts with a one, ends with a zero; bits 1-3 give type.
// - Type codes: immediate, isochronous, priority, fair, read, write, acceleration, reserved.
// - Immediate request takes the bus at idle without arbitrating.
// - Isochronous request arbitrates at idle without a subaction gap.
// - Priority ignores fairness, fair obeys it, both after a subaction gap.
// - Speed codes select S100, S200, S400; all others are invalid.
// - Invalid speed still arbitrates, but link data is dropped for a null packet.
// - All interface signals launch and sample on the rising clock edge.
// - Register requests carry address in bits 4-7; writes carry data 8-15.
// - Acceleration request bit 4 enables or disables acceleration; bit 5 stops.
module sif_link_port import sif_pkg::*; (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ISO_N,
  input wire logic [1:0] CTL_I,
  output logic [1:0] CTL_O,
  output logic [1:0] CTL_OE,
  input wire logic [7:0] D_I,
  output logic [7:0] D_O,
  output logic [7:0] D_OE,
  input wire logic LINK_REQUEST_LINE,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  input wire logic ARB_WON,
  input wire logic ARB_LOST,
  input wire logic BUS_RESET,
  output logic ARB_PENDING,
  output logic ARB_IMMEDIATE,
  output logic ARB_SKIP_GAP,
  output logic ARB_PRIORITY,
  output logic ARB_FAIR,
  output logic [2:0] BUS_SPEED,
  output logic SPEED_BAD,
  input wire logic STAT_REQ,
  input wire logic [15:0] STAT_WORD,
  output logic STAT_ACK,
  output logic [3:0] REG_RD_ADDR,
  input wire logic [7:0] REG_RD_DATA,
  output logic REG_WR_VALID,
  output logic [3:0] REG_WR_ADDR,
  output logic [7:0] REG_WR_DATA,
  output logic ACCEL_VALID,
  output logic ACCEL_EN,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_NULL
);
  sif_state_t s_ff;
  sif_state_t nxt_s;
  logic buf_valid;
  logic [8:0] buf_data;
  logic go_rx;
  logic diff;
  logic [1:0] ctl_in;
  logic [7:0] d_in;

  // ****************************************
  // Receive path buffer
  // ****************************************

  // Words from the serial side wait here while the interface is busy elsewhere.
  sif_buf u_rxbuf (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(RX_VALID),
    .in_ready(RX_READY),
    .in_data({RX_LAST, RX_DATA}),
    .out_valid(buf_valid),
    .out_ready(go_rx),
    .out_data(buf_data)
  );

  // A waiting word starts a receive at idle unless arbitration is won, and starts or continues one during status or receive.
  assign go_rx = buf_valid && (((s_ff.bus == SIF_BS_IDLE) && !s_ff.won) ||
                               (s_ff.bus == SIF_BS_STATUS) || (s_ff.bus == SIF_BS_RECV));

  // ****************************************
  // Pin views and outputs
  // ****************************************

  // Differentiation follows the synchronised isolation select.
  assign diff = !s_ff.iso_s;
  // While this end drives, the floating line keeps the level last driven.
  assign ctl_in = s_ff.own ? s_ff.ctl : CTL_I;
  assign d_in = s_ff.own ? s_ff.d : D_I;
  // Outputs come from the state register, arbiter hints from the pending request.
  assign CTL_O = s_ff.ctl;
  assign CTL_OE = s_ff.ctl_oe;
  assign D_O = s_ff.d;
  assign D_OE = s_ff.d_oe;
  assign ARB_PENDING = s_ff.bus_pend;
  assign ARB_IMMEDIATE = s_ff.bus_pend && (s_ff.bus_type == `SIF_RT_IMM);
  assign ARB_SKIP_GAP = s_ff.bus_pend && (s_ff.bus_type == `SIF_RT_ISO);
  assign ARB_PRIORITY = s_ff.bus_pend && (s_ff.bus_type == `SIF_RT_PRI);
  assign ARB_FAIR = s_ff.bus_pend && (s_ff.bus_type == `SIF_RT_FAIR);
  assign BUS_SPEED = s_ff.bus_spd;
  assign SPEED_BAD = (s_ff.bus_spd != `SIF_SPD_S100) && (s_ff.bus_spd != `SIF_SPD_S200) &&
                     (s_ff.bus_spd != `SIF_SPD_S400);
  assign STAT_ACK = s_ff.stat_ack;
  assign REG_RD_ADDR = s_ff.rd_addr;
  assign REG_WR_VALID = s_ff.wr_v;
  assign REG_WR_ADDR = s_ff.wr_addr;
  assign REG_WR_DATA = s_ff.wr_data;
  assign ACCEL_VALID = s_ff.acc_v;
  assign ACCEL_EN = s_ff.acc_en;
  assign TX_VALID = s_ff.tx_v;
  assign TX_DATA = s_ff.tx_d;
  assign TX_NULL = s_ff.null_tx;

  // ****************************************
  // Next-state logic
  // ****************************************

  // One pass decodes the request line, steps the bus owner and forms the drivers.
  always_comb begin
    logic [16:0] v;
    logic [4:0] n;
    logic [15:0] word;
    v = {s_ff.sr, LINK_REQUEST_LINE};
    n = s_ff.cnt + 5'h01;
    word = 16'h0000;
    nxt_s = s_ff;
    nxt_s.wr_v = 1'b0;
    nxt_s.acc_v = 1'b0;
    nxt_s.tx_v = 1'b0;
    nxt_s.stat_ack = 1'b0;
    nxt_s.iso_m = ISO_N;
    nxt_s.iso_s = s_ff.iso_m;
    // Serial request decoder, most significant bit first.
    unique case (s_ff.rq)
      SIF_RQ_IDLE: begin
        if (LINK_REQUEST_LINE) begin
          nxt_s.rq = SIF_RQ_BITS;
          nxt_s.cnt = 5'h01;
          nxt_s.sr = 16'h0001;
        end
      end
      SIF_RQ_BITS: begin
        nxt_s.sr = v[15:0];
        nxt_s.cnt = n;
        if (n == `SIF_LEN_TYPE) begin
          nxt_s.rtype = v[2:0];
          if (v[2:0] == `SIF_RT_RSVD) begin
            nxt_s.rq = SIF_RQ_FLUSH;
          end
        end else if (s_ff.rtype[2] == 1'b0) begin
          if (((n == `SIF_LEN_BUS_SHORT) && !v[0]) || (n == `SIF_LEN_BUS_LONG)) begin
            nxt_s.rq = SIF_RQ_IDLE;
            if (!s_ff.bus_pend) begin
              nxt_s.bus_pend = 1'b1;
              nxt_s.bus_type = s_ff.rtype;
              nxt_s.bus_spd = (n == `SIF_LEN_BUS_LONG) ? v[3:1] : v[2:0];
            end
          end
        end else if (s_ff.rtype == `SIF_RT_REG_RD) begin
          if (n == `SIF_LEN_REG_RD) begin
            nxt_s.rq = SIF_RQ_IDLE;
            if (!s_ff.rd_pend) begin
              nxt_s.rd_pend = 1'b1;
              nxt_s.rd_addr = v[4:1];
            end
          end
        end else if (s_ff.rtype == `SIF_RT_REG_WR) begin
          if (n == `SIF_LEN_REG_WR) begin
            nxt_s.rq = SIF_RQ_IDLE;
            nxt_s.wr_v = 1'b1;
            nxt_s.wr_addr = v[12:9];
            nxt_s.wr_data = v[8:1];
          end
        end else if (n == `SIF_LEN_ACCEL) begin
          nxt_s.rq = SIF_RQ_IDLE;
          nxt_s.acc_v = 1'b1;
          nxt_s.acc_en = v[1];
        end
      end
      SIF_RQ_FLUSH: begin
        if (!LINK_REQUEST_LINE) begin
          nxt_s.rq = SIF_RQ_IDLE;
        end
      end
    endcase
    // Arbitration outcome from the serial side.
    if (ARB_WON && s_ff.bus_pend) begin
      nxt_s.won = 1'b1;
    end
    // Only a request already pending can be lost, so a request landing now survives.
    if (ARB_LOST && !s_ff.won && s_ff.bus_pend) begin
      nxt_s.bus_pend = 1'b0;
    end
    // Control pair owner.
    nxt_s.ctl = `SIF_CTL_IDLE;
    nxt_s.own = 1'b1;
    unique case (s_ff.bus)
      SIF_BS_IDLE: begin
        if (s_ff.won) begin
          nxt_s.bus = SIF_BS_GRANT;
          nxt_s.ctl = `SIF_CTL_GRANT;
        end else if (go_rx) begin
          nxt_s.bus = SIF_BS_RECV;
        end else if (s_ff.rd_pend || STAT_REQ) begin
          word = s_ff.rd_pend ? {s_ff.rd_addr, REG_RD_DATA, `SIF_STAT_PAD} : STAT_WORD;
          nxt_s.bus = SIF_BS_STATUS;
          nxt_s.ctl = `SIF_CTL_STATUS;
          nxt_s.d = {6'h00, word[14], word[15]};
          nxt_s.stat_sr = {word[13:0], 2'h0};
          nxt_s.stat_cnt = 4'h1;
          nxt_s.stat_auto = !s_ff.rd_pend;
        end
      end
      SIF_BS_STATUS: begin
        if (go_rx) begin
          nxt_s.bus = SIF_BS_RECV;
        end else if (s_ff.stat_cnt == `SIF_STAT_CYC) begin
          nxt_s.bus = SIF_BS_IDLE;
          nxt_s.d = 8'h00;
          nxt_s.stat_ack = s_ff.stat_auto;
          nxt_s.rd_pend = s_ff.stat_auto ? s_ff.rd_pend : 1'b0;
        end else begin
          nxt_s.ctl = `SIF_CTL_STATUS;
          nxt_s.d = {6'h00, s_ff.stat_sr[14], s_ff.stat_sr[15]};
          nxt_s.stat_sr = {s_ff.stat_sr[13:0], 2'h0};
          nxt_s.stat_cnt = s_ff.stat_cnt + 4'h1;
        end
      end
      SIF_BS_RECV: begin
        nxt_s.ctl = `SIF_CTL_RECV;
      end
      SIF_BS_GRANT: begin
        nxt_s.bus = SIF_BS_LLC;
        nxt_s.own = 1'b0;
        nxt_s.ctl = s_ff.ctl;
        nxt_s.won = 1'b0;
        nxt_s.bus_pend = 1'b0;
        nxt_s.null_tx = SPEED_BAD;
      end
      SIF_BS_LLC: begin
        nxt_s.own = 1'b0;
        nxt_s.ctl = s_ff.ctl;
        if (ctl_in == `SIF_LCTL_RELEASE) begin
          nxt_s.bus = SIF_BS_IDLE;
          nxt_s.own = 1'b1;
          nxt_s.ctl = `SIF_CTL_IDLE;
          nxt_s.d = 8'h00;
          nxt_s.null_tx = 1'b0;
        end else if (ctl_in == `SIF_LCTL_XMIT) begin
          nxt_s.tx_v = !s_ff.null_tx;
          nxt_s.tx_d = s_ff.null_tx ? 8'h00 : d_in;
        end
      end
      default: begin
        nxt_s.bus = SIF_BS_IDLE;
      end
    endcase
    // A receive word takes the pair; fair and priority requests are lost to it.
    if (go_rx) begin
      nxt_s.bus = buf_data[8] ? SIF_BS_IDLE : SIF_BS_RECV;
      nxt_s.ctl = `SIF_CTL_RECV;
      nxt_s.d = buf_data[7:0];
      if (s_ff.bus_pend && !s_ff.won && s_ff.bus_type[1]) begin
        nxt_s.bus_pend = 1'b0;
      end
    end
    if (BUS_RESET) begin
      nxt_s.bus_pend = 1'b0;
      nxt_s.won = s_ff.won && (s_ff.bus != SIF_BS_IDLE);
    end
    // Drive fully without isolation or in the first cycle after taking the pair back, else only in the cycle of a change.
    nxt_s.ctl_oe = {2{nxt_s.own}} & ({2{!diff || !s_ff.own}} | (nxt_s.ctl ^ s_ff.ctl));
    nxt_s.d_oe = {8{nxt_s.own}} & ({8{!diff || !s_ff.own}} | (nxt_s.d ^ s_ff.d));
  end

  // State register with synchronous reset; this end owns an idle pair at reset.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_ff <= '0;
      s_ff.own <= 1'b1;
      s_ff.ctl_oe <= 2'h3;
      s_ff.d_oe <= 8'hFF;
      s_ff.iso_m <= 1'b1;
      s_ff.iso_s <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_won_idle;
    (s_ff.bus == SIF_BS_IDLE) && s_ff.won;
  endsequence
  sequence s_grant_then_release;
    (CTL_O == `SIF_CTL_GRANT) && (CTL_OE != 2'h0) ##1 (CTL_OE == 2'h0) && (D_OE == 8'h00);
  endsequence

  AST_GRANT_HANDOVER: assert property (s_won_idle |=> s_grant_then_release)
    else $error("Grant was not followed by release of the pair.");
  AST_RECV_CODE: assert property ($rose(go_rx) && (s_ff.bus != SIF_BS_LLC) |=>
                                  CTL_O == `SIF_CTL_RECV)
    else $error("Receive code missing after a buffered packet word.");
  AST_FULL_DRIVE: assert property (s_ff.iso_s && $past(s_ff.iso_s) && s_ff.own |->
                                   (CTL_OE == 2'h3) && (D_OE == 8'hFF))
    else $error("Outputs not fully driven with differentiation off.");
  AST_DIFF_FLOAT: assert property (!s_ff.iso_s && $past(!s_ff.iso_s) && s_ff.own &&
                                   $past(s_ff.own) && $stable(CTL_O) |-> CTL_OE == 2'h0)
    else $error("Differentiated control pair driven without a change.");
  AST_WR_FRAME: assert property (REG_WR_VALID |-> $past(LINK_REQUEST_LINE, 17) &&
                                 !$past(LINK_REQUEST_LINE, 1))
    else $error("Register write decoded without start or stop bit.");
  AST_ACCEL_LEN: assert property (ACCEL_VALID |-> $past(LINK_REQUEST_LINE, 6) &&
                                  ($past(s_ff.rq, 6) == SIF_RQ_IDLE))
    else $error("Acceleration request length wrong.");
  AST_NULL_DROP: assert property (TX_NULL |-> !TX_VALID)
    else $error("Link data passed on for an invalid speed.");
  AST_STATUS_LEN: assert property (STAT_ACK |-> $past(CTL_O == `SIF_CTL_STATUS, 1) &&
                                   $past(CTL_O == `SIF_CTL_STATUS, 8) &&
                                   !$past(CTL_O == `SIF_CTL_STATUS, 9))
    else $error("Status transfer did not last eight cycles.");
  AST_PEND_KEEP: assert property (ARB_PENDING && !ARB_LOST && !BUS_RESET && !go_rx &&
                                  (s_ff.bus != SIF_BS_GRANT) |=>
                                  ARB_PENDING && $stable(BUS_SPEED))
    else $error("Pending bus request changed by a new request.");
endmodule // sif_link_port

//--- sif_llc_model.sv
// Behavioural link-layer controller: serial requests and one-word transmits.
`timescale 1ns/1ps
`include "sif_defines.svh"
module sif_llc_model (
  input wire logic clk,
  input wire logic [1:0] ctl_w,
  output logic link_request_line,
  output logic [1:0] llc_ctl,
  output logic [7:0] llc_d,
  output logic llc_oe
);
  // ********************************
  // Request line and bus drivers
  // ********************************
  // Everything rests released, and the request line stays low between streams.
  initial begin
    link_request_line = 1'b0;
    llc_ctl = `SIF_LCTL_RELEASE;
    llc_d = 8'h00;
    llc_oe = 1'b0;
  end
  // Sends the first n bits of a left-aligned stream, most significant bit first.
  task automatic send_req(input logic [16:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      link_request_line = bits[16-i];
    end
  endtask
  // Waits for the grant, holds one cycle, sends one word, then releases the pair.
  task automatic transmit(input logic [7:0] data);
    for (int k = 0; k < 100 && ctl_w !== `SIF_CTL_GRANT; k++) @(negedge clk);
    @(negedge clk);
    llc_oe = 1'b1;
    llc_ctl = `SIF_LCTL_HOLD;
    @(negedge clk);
    llc_ctl = `SIF_LCTL_XMIT;
    llc_d = data;
    @(negedge clk);
    llc_ctl = `SIF_LCTL_RELEASE;
    llc_d = ~data;
    repeat (2) @(negedge clk);
    llc_oe = 1'b0;
  endtask
endmodule // sif_llc_model

//--- sif_link_port_bench.sv
// Self-checking bench for the device side of the link-layer interface.
`timescale 1ns/1ps
`include "sif_defines.svh"
module sif_link_port_bench;
  logic clk, rst_n, iso_n, link_request_line, rx_valid, rx_ready, rx_last;
  logic arb_won, arb_lost, bus_reset;
  logic stat_req, stat_ack, llc_oe, arb_pending, arb_imm, arb_skip, arb_pri, arb_fair;
  logic speed_bad, reg_wr_valid, accel_valid, accel_en, tx_valid, tx_null;
  logic [1:0] ctl_o, ctl_oe, ctl_w, ctl_hold_ff, llc_ctl;
  logic [7:0] d_o, d_oe, d_w, d_hold_ff, llc_d, rx_data, reg_rd_data, tx_data, reg_wr_data;
  logic [2:0] bus_speed;
  logic [3:0] reg_rd_addr, reg_wr_addr;
  logic [15:0] stat_word;
  logic [1:0] stat_q[$];
  logic [7:0] rx_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // *******************
  // Clock, wires, monitor
  // *******************
  // The clock toggles every half period of 5 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A released line keeps its level under isolation, otherwise it toggles.
  assign ctl_w = (ctl_oe & ctl_o) |
                 (~ctl_oe & (llc_oe ? llc_ctl : (iso_n ? ~ctl_hold_ff : ctl_hold_ff)));
  assign d_w = (d_oe & d_o) | (~d_oe & (llc_oe ? llc_d : (iso_n ? ~d_hold_ff : d_hold_ff)));
  // Remembers wire levels, collects transfer data and cuts a hang short.
  always @(posedge clk) begin
    ctl_hold_ff <= ctl_w;
    d_hold_ff <= d_w;
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  always @(negedge clk) begin
    if (ctl_o === `SIF_CTL_STATUS) stat_q.push_back(d_o[1:0]);
    if (ctl_o === `SIF_CTL_RECV) rx_q.push_back(d_o);
  end
  sif_llc_model llc (.clk(clk), .ctl_w(ctl_w), .link_request_line(link_request_line),
    .llc_ctl(llc_ctl), .llc_d(llc_d), .llc_oe(llc_oe));
  sif_link_port dut (.CLK(clk), .RST_N(rst_n), .ISO_N(iso_n), .CTL_I(ctl_w), .CTL_O(ctl_o),
    .CTL_OE(ctl_oe), .D_I(d_w), .D_O(d_o), .D_OE(d_oe),
    .LINK_REQUEST_LINE(link_request_line), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_LAST(rx_last), .ARB_WON(arb_won),
    .ARB_LOST(arb_lost), .BUS_RESET(bus_reset), .ARB_PENDING(arb_pending),
    .ARB_IMMEDIATE(arb_imm), .ARB_SKIP_GAP(arb_skip), .ARB_PRIORITY(arb_pri),
    .ARB_FAIR(arb_fair), .BUS_SPEED(bus_speed), .SPEED_BAD(speed_bad), .STAT_REQ(stat_req),
    .STAT_WORD(stat_word), .STAT_ACK(stat_ack), .REG_RD_ADDR(reg_rd_addr),
    .REG_RD_DATA(reg_rd_data), .REG_WR_VALID(reg_wr_valid), .REG_WR_ADDR(reg_wr_addr),
    .REG_WR_DATA(reg_wr_data), .ACCEL_VALID(accel_valid), .ACCEL_EN(accel_en),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_NULL(tx_null));
  // *******************
  // Shared tasks
  // *******************
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Waits a bounded time for a control code on the pair.
  task automatic wait_ctl(input logic [1:0] code);
    for (int k = 0; k < 60 && ctl_o !== code; k++) @(negedge clk);
    check(ctl_o, code, "control code");
  endtask
  // Checks eight status cycles: bit 0 carries the higher bit of each pair.
  task automatic stat_cmp(input logic [15:0] w);
    check(16'(stat_q.size()), 16'h8, "status length");
    for (int i = 0; i < 8; i++) check(stat_q[i], {w[14-2*i], w[15-2*i]}, "status bits");
  endtask
  // Offers one received word and holds it until the buffer takes it.
  task automatic rx_push(input logic [7:0] w, input logic last);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = w;
    rx_last = last;
    for (int k = 0; k < 20 && rx_ready !== 1'b1; k++) @(negedge clk);
  endtask
  // *******************
  // Scenarios
  // *******************
  task automatic t_reset();
    check({d_oe, ctl_oe, ctl_o}, {8'hFF, 2'h3, `SIF_CTL_IDLE}, "reset control");
    check(rx_ready, 1'b1, "buffer empty");
    $display("test reset done");
  endtask
  // A reserved stream directly before a write, then both acceleration settings.
  task automatic t_write_accel();
    llc.send_req({5'b11110, 12'h000}, 5);
    llc.send_req({1'b1, `SIF_RT_REG_WR, 4'hA, 8'h5C, 1'b0}, 17);
    tick(1);
    check({reg_wr_valid, reg_wr_addr, reg_wr_data}, {1'b1, 12'hA5C}, "write");
    check(arb_pending, 1'b0, "reserved ignored");
    tick(1);
    check(reg_wr_valid, 1'b0, "write strobe width");
    for (int e = 1; e >= 0; e--) begin
      llc.send_req({1'b1, `SIF_RT_ACCEL, e[0], 1'b0, 11'h000}, 6);
      tick(1);
      check({accel_valid, accel_en}, {1'b1, e[0]}, "acceleration");
    end
    $display("test write and acceleration done");
  endtask
  // Every bus request type and speed class, a refused second request, two clears.
  task automatic t_bus();
    logic [2:0] spd [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
    for (int t = 0; t < 4; t++) begin
      llc.send_req({1'b1, t[2:0], spd[t], 1'b0, 9'h000}, spd[t][0] ? 8 : 7);
      tick(2);
      check({arb_pending, arb_imm, arb_pri, arb_fair}, {1'b1, t == 0, t == 2, t == 3}, "kind");
      if (t > 0) check(arb_skip, t == 1, "gap skip");
      check({speed_bad, bus_speed}, {t == 3, spd[t]}, "speed");
      llc.send_req({1'b1, `SIF_RT_FAIR, 3'h2, 1'b0, 9'h000}, 7);
      tick(2);
      check(bus_speed, spd[t], "second request");
      arb_lost = t[0];
      bus_reset = ~t[0];
      tick(1);
      arb_lost = 1'b0;
      bus_reset = 1'b0;
      tick(1);
      check(arb_pending, 1'b0, "request cleared");
    end
    $display("test bus requests done");
  endtask
  task automatic t_read();
    stat_q = {};
    reg_rd_data = 8'h3C;
    llc.send_req({1'b1, `SIF_RT_REG_RD, 4'h9, 1'b0, 8'h00}, 9);
    tick(2);
    check(reg_rd_addr, 4'h9, "read address");
    wait_ctl(`SIF_CTL_STATUS);
    wait_ctl(`SIF_CTL_IDLE);
    stat_cmp(16'h93C0);
    $display("test register read done");
  endtask
  // Autonomous status with differentiation on: only changed bits are driven.
  task automatic t_iso();
    stat_q = {};
    iso_n = 1'b0;
    stat_word = 16'hA5C3;
    tick(6);
    check(ctl_oe, 2'h0, "idle floats");
    stat_req = 1'b1;
    wait_ctl(`SIF_CTL_STATUS);
    stat_req = 1'b0;
    check(ctl_oe, 2'h2, "changed bit driven");
    check(d_oe, 8'h01, "changed data bit driven");
    tick(1);
    check(ctl_oe, 2'h0, "steady bits float");
    for (int k = 0; k < 20 && stat_ack !== 1'b1; k++) @(negedge clk);
    check(stat_ack, 1'b1, "status acknowledged");
    wait_ctl(`SIF_CTL_IDLE);
    stat_cmp(16'hA5C3);
    iso_n = 1'b1;
    tick(6);
    $display("test differentiation done");
  endtask
  task automatic t_grant(input logic [2:0] spd, input logic [7:0] data, input logic nul);
    llc.send_req({1'b1, `SIF_RT_ISO, spd, 1'b0, 9'h000}, 7);
    tick(2);
    arb_won = 1'b1;
    tick(1);
    arb_won = 1'b0;
    fork
      llc.transmit(data);
      begin
        // A null grant passes no word, so look only up to the link's transmit cycle.
        for (int k = 0; k < (nul ? 4 : 40) && tx_valid !== 1'b1; k++) @(negedge clk);
        check(tx_valid, !nul, "transmit word");
        check(tx_null, nul, "null packet");
        if (!nul) check(tx_data, data, "transmit data");
      end
    join
    tick(1);
    check({ctl_oe, ctl_o, arb_pending}, {2'h3, `SIF_CTL_IDLE, 1'b0}, "idle again");
    $display("test grant done");
  endtask
  task automatic t_recv();
    logic [7:0] w [3] = '{8'h11, 8'h22, 8'h33};
    rx_q = {};
    for (int i = 0; i < 3; i++) rx_push(w[i], i == 2);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    wait_ctl(`SIF_CTL_IDLE);
    check(16'(rx_q.size()), 16'h3, "receive length");
    for (int i = 0; i < 3; i++) check(rx_q[i], w[i], "receive word");
    $display("test receive done");
  endtask
  // Main sequence: reset for four cycles, then every scenario in turn.
  initial begin
    {rst_n, rx_valid, rx_last, arb_won, arb_lost, bus_reset, stat_req} = 7'h00;
    iso_n = 1'b1;
    {rx_data, reg_rd_data} = 16'h0000;
    stat_word = 16'h0000;
    tick(4);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_write_accel();
    t_bus();
    t_read();
    t_iso();
    t_grant(3'h4, 8'hC6, 1'b0);
    t_grant(3'h6, 8'h39, 1'b1);
    t_recv();
    print_verdict();
  end
endmodule // sif_link_port_bench
